//--- iqsm_cfg.svh
`ifndef IQSM_CFG_SVH
`define IQSM_CFG_SVH

// ************************************************************
// Register addresses on the serial command interface
// ************************************************************
`define IQSM_ADDR_RESULT 4'h0
`define IQSM_ADDR_STATUS 4'h5
`define IQSM_ADDR_INSEL 4'h6

// ************************************************************
// Field positions of the interrupt and status register
// ************************************************************
`define IQSM_BIT_UNUSED 7
`define IQSM_BIT_RDY 6
`define IQSM_BIT_CRC 5
`define IQSM_BIT_POR 4
`define IQSM_BIT_PINSEL 3
`define IQSM_BIT_PINIDLE 2
`define IQSM_BIT_QCMD 1
`define IQSM_BIT_CSIRQ 0

// ************************************************************
// Field positions of the input select register
// ************************************************************
`define IQSM_POS_HI 7
`define IQSM_POS_LO 4
`define IQSM_NEG_HI 3
`define IQSM_NEG_LO 0

// ************************************************************
// Reset values
// ************************************************************
`define IQSM_RST_CFG 4'h3
`define IQSM_RST_INSEL 8'h01
`define IQSM_RST_FLAG 1'b1

// ************************************************************
// Command byte layout and command types
// ************************************************************
`define IQSM_CMD_DEV_HI 7
`define IQSM_CMD_DEV_LO 6
`define IQSM_CMD_ADR_HI 5
`define IQSM_CMD_ADR_LO 2
`define IQSM_CMD_TYP_HI 1
`define IQSM_CMD_TYP_LO 0
`define IQSM_CMD_FAST 2'h0
`define IQSM_CMD_SREAD 2'h1
`define IQSM_CMD_WRITE 2'h2
`define IQSM_CMD_IREAD 2'h3

`endif

//--- iqsm_host_model.sv
`timescale 1ns/10ps
// ************************************************************
// Host side of the serial command link, mode 0, MSB first
// ************************************************************
module iqsm_host_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  import iqsm_pkg::*;
  // Half period well above the 2-flop sync delay
  localparam int HALF = 8;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic frame(input iqsm_byte_t b0, input iqsm_byte_t b1,
                       input int nb, output iqsm_byte_t r0,
                       output iqsm_byte_t r1);
    iqsm_byte_t tx;
    iqsm_byte_t rx;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (HALF) @(posedge clk);
    for (int k = 0; k < nb; k++) begin
      tx = (k == 0) ? b0 : b1;
      for (int i = 7; i >= 0; i--) begin
        mosi <= tx[i];
        repeat (HALF) @(posedge clk);
        sclk <= 1'b1;
        // Released line is not trusted
        rx[i] = (miso_oe_n === 1'b0) ? miso : 1'bx;
        repeat (HALF) @(posedge clk);
        sclk <= 1'b0;
      end
      if (k == 0) r0 = rx;
      else r1 = rx;
    end
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    repeat (2 * HALF) @(posedge clk);
  endtask
endmodule

//--- iqsm_link_ser.sv
`timescale 1ns/10ps
module iqsm_link_ser (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic tx_load,
  input wire iqsm_pkg::iqsm_byte_t tx_byte,
  output logic miso,
  output logic miso_oe_n,
  output logic rx_valid,
  output iqsm_pkg::iqsm_byte_t rx_byte,
  output logic frame_start,
  output logic frame_active
);
  import iqsm_pkg::*;

  // ************************************************************
  // Pin synchronisers, order is {sclk, cs_n, mosi}
  // ************************************************************
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;
  logic [2:0] cnt_q, cnt_d;
  iqsm_byte_t sh_q, sh_d;
  iqsm_byte_t tx_q, tx_d;
  iqsm_byte_t rxb_q, rxb_d;
  logic miso_q, miso_d;
  logic rxv_q, rxv_d;
  logic fs_q, fs_d;
  logic act_q, act_d;
  logic oe_n_q, oe_n_d;
  logic rise, fall, cs_act;

  assign rise = sync2_q[2] & ~prev_q[2];
  assign fall = ~sync2_q[2] & prev_q[2];
  assign cs_act = ~sync2_q[1];

  // ************************************************************
  // Mode 0 shifter: sample on rise, shift out on fall
  // ************************************************************
  always_comb begin
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    rxb_d = rxb_q;
    miso_d = miso_q;
    rxv_d = 1'b0;
    fs_d = cs_act & ~act_q;
    act_d = cs_act;
    oe_n_d = ~cs_act;
    if (!cs_act) begin
      cnt_d = 3'h0;
    end else begin
      if (rise) begin
        sh_d = {sh_q[6:0], sync2_q[0]};
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          rxv_d = 1'b1;
          rxb_d = {sh_q[6:0], sync2_q[0]};
        end
      end
      // No shift on the fall that closes a byte, the next byte loads
      if (fall && cnt_q != 3'h0) begin
        tx_d = {tx_q[6:0], 1'b0};
        miso_d = tx_q[6];
      end
    end
    if (tx_load) begin
      tx_d = tx_byte;
      miso_d = tx_byte[7];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 3'h2;
      sync2_q <= 3'h2;
      prev_q <= 3'h2;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      rxb_q <= 8'h00;
      miso_q <= 1'b0;
      rxv_q <= 1'b0;
      fs_q <= 1'b0;
      act_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      sync1_q <= {sclk, cs_n, mosi};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      rxb_q <= rxb_d;
      miso_q <= miso_d;
      rxv_q <= rxv_d;
      fs_q <= fs_d;
      act_q <= act_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign miso = miso_q;
  assign miso_oe_n = oe_n_q;
  assign rx_valid = rxv_q;
  assign rx_byte = rxb_q;
  assign frame_start = fs_q;
  assign frame_active = act_q;
endmodule

//--- iqsm_pin_drv.sv
`timescale 1ns/10ps
module iqsm_pin_drv (
  input wire logic clk,
  input wire logic rst,
  input wire logic sel_bitstream,
  input wire logic idle_drive,
  input wire logic irq_any,
  input wire logic irq_priority,
  input wire logic bitstream,
  output logic pin_out,
  output logic pin_oe_n
);
  import iqsm_pkg::*;

  logic out_q, out_d;
  logic oe_n_q, oe_n_d;

  // ************************************************************
  // Shared pin: interrupts low, idle high or released
  // ************************************************************
  always_comb begin
    out_d = 1'b1;
    oe_n_d = 1'b1;
    if (sel_bitstream) begin
      // Bitstream yields only to the power-on and integrity events
      out_d = irq_priority ? 1'b0 : bitstream;
      oe_n_d = 1'b0;
    end else if (irq_any) begin
      out_d = 1'b0;
      oe_n_d = 1'b0;
    end else if (idle_drive) begin
      oe_n_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else begin
      out_q <= out_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign pin_out = out_q;
  assign pin_oe_n = oe_n_q;
endmodule

//--- iqsm_pkg.sv
package iqsm_pkg;
  typedef logic [7:0] iqsm_byte_t;
  typedef logic [3:0] iqsm_addr_t;
  typedef logic [1:0] iqsm_dev_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_WDATA, ST_SKIP} iqsm_state_e;
endpackage

//--- iqsm_regs.sv
`timescale 1ns/10ps
`include "iqsm_cfg.svh"
// Overview of operation
// - Result-ready flag bit 6 resets 1, goes 0 on new result, read sets 1.
// - Integrity flag bit 5 reads 1 unless a configuration CRC error shows.
// - Power-on flag bit 4 reads 0 after a power-on event until read.
// - Pin field bits 3-2 resets 00; upper bit picks interrupt or bitstream.
// - In bitstream mode only power-on and CRC events override the stream.
// - Lower pin bit: 1 drives idle high, 0 releases pin when idle.
// - Conversion-start interrupt raised only while bit 0 is set; resets 1.
// - Pin field 10 or 11 routes modulator codes to pin and result.
// - Code 1010 reserved; 1001 analogue supply; 1000 analogue ground.
// - Codes 0111-0000 pick channels 7-0; positive selector resets to 0.
// - Input select register, 8-bit read/write at 0x6, resets to 0x01.
// - Negative selector shares codes and resets to channel 1.
module iqsm_regs #(
  parameter iqsm_pkg::iqsm_dev_t DEV_ADDR = 2'h1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  input wire logic result_valid,
  input wire logic conv_start,
  input wire logic crc_error,
  input wire logic por_event,
  input wire logic modulator_bitstream,
  output logic shared_event_pin_o,
  output logic shared_event_pin_oe_n,
  output iqsm_pkg::iqsm_addr_t positive_input_sel,
  output iqsm_pkg::iqsm_addr_t negative_input_sel,
  output logic result_from_modulator,
  output logic conv_start_irq,
  output logic quick_cmd_valid,
  output iqsm_pkg::iqsm_addr_t quick_cmd_code
);
  import iqsm_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  iqsm_state_e st_q, st_d;
  iqsm_addr_t adr_q, adr_d;
  logic [3:0] cfg_q, cfg_d;
  iqsm_byte_t insel_q, insel_d;
  logic rdy_n_q, rdy_n_d;
  logic crc_ok_q, crc_ok_d;
  logic por_n_q, por_n_d;
  logic csirq_q, csirq_d;
  logic qv_q, qv_d;
  iqsm_addr_t qc_q, qc_d;
  logic txl_q, txl_d;
  iqsm_byte_t txb_q, txb_d;

  logic rx_valid;
  iqsm_byte_t rx_byte;
  logic frame_start;
  logic frame_active;
  logic rd_result, rd_status;
  logic wr_status, wr_insel;
  logic irq_any, irq_prio;
  iqsm_byte_t status_byte;
  iqsm_dev_t cmd_dev;
  iqsm_addr_t cmd_adr;
  logic [1:0] cmd_typ;

  // Read data mux, shared by the frame opener and by read commands
  function automatic iqsm_byte_t read_mux(input iqsm_addr_t a,
                                          input iqsm_byte_t stat,
                                          input iqsm_byte_t isel);
    iqsm_byte_t r;
    r = 8'h00;
    if (a == `IQSM_ADDR_STATUS) begin
      r = stat;
    end else if (a == `IQSM_ADDR_INSEL) begin
      r = isel;
    end
    return r;
  endfunction

  assign status_byte = {1'b0, rdy_n_q, crc_ok_q, por_n_q, cfg_q};
  assign cmd_dev = rx_byte[`IQSM_CMD_DEV_HI:`IQSM_CMD_DEV_LO];
  assign cmd_adr = rx_byte[`IQSM_CMD_ADR_HI:`IQSM_CMD_ADR_LO];
  assign cmd_typ = rx_byte[`IQSM_CMD_TYP_HI:`IQSM_CMD_TYP_LO];

  iqsm_link_ser u_link (
    .clk(clk),
    .rst(rst),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .tx_load(txl_q),
    .tx_byte(txb_q),
    .miso(miso),
    .miso_oe_n(miso_oe_n),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .frame_start(frame_start),
    .frame_active(frame_active)
  );

  // ************************************************************
  // Command decoder
  // ************************************************************
  always_comb begin
    st_d = st_q;
    adr_d = adr_q;
    qv_d = 1'b0;
    qc_d = qc_q;
    txl_d = 1'b0;
    txb_d = txb_q;
    rd_result = 1'b0;
    rd_status = 1'b0;
    wr_status = 1'b0;
    wr_insel = 1'b0;
    if (!frame_active) begin
      st_d = ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          // Status byte goes out while the command shifts in
          if (frame_start) begin
            txl_d = 1'b1;
            txb_d = read_mux(`IQSM_ADDR_STATUS, status_byte, insel_q);
            st_d = ST_CMD;
          end
        end
        ST_CMD: begin
          if (rx_valid) begin
            st_d = ST_SKIP;
            if (cmd_dev == DEV_ADDR) begin
              unique case (cmd_typ)
                `IQSM_CMD_FAST: begin
                  qv_d = cfg_q[`IQSM_BIT_QCMD];
                  qc_d = cmd_adr;
                end
                `IQSM_CMD_WRITE: begin
                  adr_d = cmd_adr;
                  st_d = ST_WDATA;
                end
                default: begin
                  txl_d = 1'b1;
                  txb_d = read_mux(cmd_adr, status_byte, insel_q);
                  rd_result = (cmd_adr == `IQSM_ADDR_RESULT);
                  rd_status = (cmd_adr == `IQSM_ADDR_STATUS);
                end
              endcase
            end
          end
        end
        ST_WDATA: begin
          if (rx_valid) begin
            wr_status = (adr_q == `IQSM_ADDR_STATUS);
            wr_insel = (adr_q == `IQSM_ADDR_INSEL);
            st_d = ST_SKIP;
          end
        end
        ST_SKIP: begin
          st_d = ST_SKIP;
        end
      endcase
    end
  end

  // ************************************************************
  // Register file and status flags
  // ************************************************************
  always_comb begin
    cfg_d = cfg_q;
    insel_d = insel_q;
    if (wr_status) begin
      cfg_d = rx_byte[3:0];
    end
    if (wr_insel) begin
      insel_d = rx_byte;
    end
    rdy_n_d = rdy_n_q;
    if (result_valid) begin
      rdy_n_d = 1'b0;
    end else if (rd_result) begin
      rdy_n_d = 1'b1;
    end
    crc_ok_d = ~crc_error;
    por_n_d = por_n_q;
    if (por_event) begin
      por_n_d = 1'b0;
    end else if (rd_status) begin
      por_n_d = 1'b1;
    end
    csirq_d = conv_start & cfg_q[`IQSM_BIT_CSIRQ];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      adr_q <= 4'h0;
      cfg_q <= `IQSM_RST_CFG;
      insel_q <= `IQSM_RST_INSEL;
      rdy_n_q <= `IQSM_RST_FLAG;
      crc_ok_q <= `IQSM_RST_FLAG;
      por_n_q <= `IQSM_RST_FLAG;
      csirq_q <= 1'b0;
      qv_q <= 1'b0;
      qc_q <= 4'h0;
      txl_q <= 1'b0;
      txb_q <= 8'h00;
    end else begin
      st_q <= st_d;
      adr_q <= adr_d;
      cfg_q <= cfg_d;
      insel_q <= insel_d;
      rdy_n_q <= rdy_n_d;
      crc_ok_q <= crc_ok_d;
      por_n_q <= por_n_d;
      csirq_q <= csirq_d;
      qv_q <= qv_d;
      qc_q <= qc_d;
      txl_q <= txl_d;
      txb_q <= txb_d;
    end
  end

  // ************************************************************
  // Shared event pin
  // ************************************************************
  assign irq_prio = ~crc_ok_q | ~por_n_q;
  assign irq_any = irq_prio | ~rdy_n_q | csirq_q;

  iqsm_pin_drv u_pin (
    .clk(clk),
    .rst(rst),
    .sel_bitstream(cfg_q[`IQSM_BIT_PINSEL]),
    .idle_drive(cfg_q[`IQSM_BIT_PINIDLE]),
    .irq_any(irq_any),
    .irq_priority(irq_prio),
    .bitstream(modulator_bitstream),
    .pin_out(shared_event_pin_o),
    .pin_oe_n(shared_event_pin_oe_n)
  );

  assign positive_input_sel = insel_q[`IQSM_POS_HI:`IQSM_POS_LO];
  assign negative_input_sel = insel_q[`IQSM_NEG_HI:`IQSM_NEG_LO];
  assign result_from_modulator = cfg_q[`IQSM_BIT_PINSEL];
  assign conv_start_irq = csirq_q;
  assign quick_cmd_valid = qv_q;
  assign quick_cmd_code = qc_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_prio_stream;
    cfg_q[`IQSM_BIT_PINSEL] && irq_prio;
  endsequence

  sequence s_quiet_float;
    !cfg_q[`IQSM_BIT_PINSEL] && !cfg_q[`IQSM_BIT_PINIDLE] && !irq_any;
  endsequence

  property p_rdy_set;
    @(posedge clk) disable iff (rst)
    result_valid |=> !rdy_n_q && status_byte[`IQSM_BIT_RDY] == 1'b0;
  endproperty
  a_rdy_set: assert property (p_rdy_set)
    else $error("result flag not low after new result");

  property p_rdy_clr;
    @(posedge clk) disable iff (rst)
    rd_result && !result_valid |=> rdy_n_q;
  endproperty
  a_rdy_clr: assert property (p_rdy_clr)
    else $error("result flag not restored by read");

  property p_crc;
    @(posedge clk) disable iff (rst)
    crc_error |=> !status_byte[`IQSM_BIT_CRC] ##1
      !shared_event_pin_o && !shared_event_pin_oe_n;
  endproperty
  a_crc: assert property (p_crc)
    else $error("integrity error not shown");

  property p_por;
    @(posedge clk) disable iff (rst)
    por_event |=> !por_n_q;
  endproperty
  a_por: assert property (p_por)
    else $error("power-on flag not low after event");

  property p_prio;
    @(posedge clk) disable iff (rst)
    s_prio_stream |=> !shared_event_pin_o && !shared_event_pin_oe_n;
  endproperty
  a_prio: assert property (p_prio)
    else $error("priority event did not override bitstream");

  property p_float;
    @(posedge clk) disable iff (rst)
    s_quiet_float |=> shared_event_pin_oe_n;
  endproperty
  a_float: assert property (p_float)
    else $error("idle pin not released");

  property p_qcmd;
    @(posedge clk) disable iff (rst)
    !cfg_q[`IQSM_BIT_QCMD] |=> !quick_cmd_valid;
  endproperty
  a_qcmd: assert property (p_qcmd)
    else $error("fast command taken while disabled");

  property p_csirq;
    @(posedge clk) disable iff (rst)
    conv_start |=> conv_start_irq == $past(cfg_q[`IQSM_BIT_CSIRQ]);
  endproperty
  a_csirq: assert property (p_csirq)
    else $error("conversion start interrupt wrong");

  property p_insel;
    @(posedge clk) disable iff (rst)
    wr_insel |=> insel_q == $past(rx_byte);
  endproperty
  a_insel: assert property (p_insel)
    else $error("input select write lost");

  property p_ro;
    @(posedge clk) disable iff (rst)
    wr_status && !result_valid && !rd_result |=> rdy_n_q == $past(rdy_n_q);
  endproperty
  a_ro: assert property (p_ro)
    else $error("write disturbed a read-only flag");
endmodule

//--- test_iqsm_regs.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_iqsm_regs;
  import iqsm_pkg::*;
  localparam iqsm_dev_t DEV = 2'h1;
  logic clk, rst, sclk, cs_n, mosi, miso, miso_oe_n;
  logic result_valid, conv_start, crc_error, por_event, modulator_bitstream;
  logic pin_o, pin_oe_n, result_from_modulator, conv_start_irq;
  logic quick_cmd_valid;
  iqsm_addr_t positive_input_sel, negative_input_sel, quick_cmd_code;
  iqsm_byte_t st, d;
  int bad_count, n_tests, qv_cnt, cs_cnt, pl_cnt;

  iqsm_regs #(.DEV_ADDR(DEV)) iqsm_regs_i (.clk(clk), .rst(rst),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n), .result_valid(result_valid),
    .conv_start(conv_start), .crc_error(crc_error), .por_event(por_event),
    .modulator_bitstream(modulator_bitstream),
    .shared_event_pin_o(pin_o), .shared_event_pin_oe_n(pin_oe_n),
    .positive_input_sel(positive_input_sel),
    .negative_input_sel(negative_input_sel),
    .result_from_modulator(result_from_modulator),
    .conv_start_irq(conv_start_irq), .quick_cmd_valid(quick_cmd_valid),
    .quick_cmd_code(quick_cmd_code));
  iqsm_host_model iqsm_host_model_i (.clk(clk), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n));

  // ************************************************************
  // Clock, event monitors
  // ************************************************************
  initial clk = 1'b0;
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (quick_cmd_valid === 1'b1) qv_cnt++;
    if (conv_start_irq === 1'b1) cs_cnt++;
    if (pin_oe_n === 1'b0 && pin_o === 1'b0) pl_cnt++;
  end

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic wr(input iqsm_addr_t a, input iqsm_byte_t v);
    iqsm_byte_t r0;
    iqsm_byte_t r1;
    iqsm_host_model_i.frame({DEV, a, 2'h2}, v, 2, r0, r1);
  endtask
  task automatic rd(input iqsm_addr_t a);
    iqsm_host_model_i.frame({DEV, a, 2'h1}, 8'h00, 2, st, d);
  endtask
  task automatic fast(input iqsm_addr_t c);
    iqsm_byte_t r1;
    iqsm_host_model_i.frame({DEV, c, 2'h0}, 8'h00, 1, st, r1);
  endtask
  // Event inputs are one-cycle pulses
  task automatic pulse(input int w);
    @(posedge clk);
    if (w == 0) result_valid <= 1'b1;
    else if (w == 1) conv_start <= 1'b1;
    else por_event <= 1'b1;
    @(posedge clk);
    {result_valid, conv_start, por_event} <= 3'b000;
    repeat (6) @(posedge clk);
  endtask
  task automatic pin(input logic oe, input logic o);
    repeat (4) @(posedge clk);
    `CHK("pin_oe_n", oe, pin_oe_n)
    if (oe == 1'b0) `CHK("pin_o", o, pin_o)
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    {result_valid, conv_start, crc_error, por_event} = 4'h0;
    modulator_bitstream = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("pos_sel", 4'h0, positive_input_sel)
    `CHK("neg_sel", 4'h1, negative_input_sel)
    `CHK("from_mod0", 1'b0, result_from_modulator)
    pin(1'b1, 1'b1);
    rd(4'h5);
    `CHK("status", 8'h73, d)
    rd(4'h6);
    `CHK("insel", 8'h01, d)
    pulse(1);
    `CHK("cs_irq", 1, cs_cnt)
    `CHK("pin_low", 1, pl_cnt)
    wr(4'h5, 8'h72);
    pulse(1);
    `CHK("cs_irq_off", 1, cs_cnt)
    fast(4'h9);
    `CHK("qcmd", 1, qv_cnt)
    `CHK("qcode", 4'h9, quick_cmd_code)
    wr(4'h5, 8'h70);
    fast(4'h4);
    `CHK("qcmd_off", 1, qv_cnt)
    // Read-only bits must survive an all-ones write
    wr(4'h5, 8'hff);
    rd(4'h5);
    `CHK("status_ro", 8'h7f, d)
    `CHK("from_mod", 1'b1, result_from_modulator)
    modulator_bitstream <= 1'b1;
    pin(1'b0, 1'b1);
    modulator_bitstream <= 1'b0;
    pin(1'b0, 1'b0);
    modulator_bitstream <= 1'b1;
    pulse(0);
    pin(1'b0, 1'b1);
    crc_error <= 1'b1;
    pin(1'b0, 1'b0);
    rd(4'h0);
    `CHK("result", 8'h00, d)
    rd(4'h5);
    `CHK("crc_flag", 8'h5f, st)
    crc_error <= 1'b0;
    pulse(2);
    rd(4'h5);
    `CHK("por_flag", 8'h6f, st)
    rd(4'h5);
    `CHK("por_clr", 8'h7f, st)
    wr(4'h5, 8'h74);
    pin(1'b0, 1'b1);
    pulse(0);
    pin(1'b0, 1'b0);
    rd(4'h0);
    pin(1'b0, 1'b1);
    wr(4'h5, 8'h70);
    pin(1'b1, 1'b1);
    for (int c = 0; c < 16; c++) begin
      wr(4'h6, {c[3:0], ~c[3:0]});
      `CHK("pos_sel", c[3:0], positive_input_sel)
      `CHK("neg_sel", ~c[3:0], negative_input_sel)
      rd(4'h6);
      `CHK("insel_rb", {c[3:0], ~c[3:0]}, d)
    end
    wr(4'h6, 8'hde);
    `CHK("temp_sel", 8'hde, {positive_input_sel, negative_input_sel})
    // Foreign device address must leave the register alone
    iqsm_host_model_i.frame({2'h2, 4'h6, 2'h2}, 8'h00, 2, st, d);
    rd(4'h6);
    `CHK("insel_dev", 8'hde, d)
    rd(4'h3);
    `CHK("unmapped", 8'h00, d)
    test_done();
  end

  // Whole run is about 14.6k cycles; over three times that is a hang
  initial begin
    repeat (50000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule
